// [verification/testbench.sv]
// Purpose: self-checking bench for the frame sync flywheel
// Assumes: framer model supplies line clock, syncs and rx data
// Notes: event pulses are counted in the background
`timescale 1ns/10ps
module testbench;
  typedef struct {
    logic [2:0] fmt;
    int len;
    int slot;
  } tfsf_row_t;
  localparam int CEIL = 95000;
  tfsf_row_t rows [4];
  logic clk, rst, sync_en, nx64, slip, loss_of_frame, abt, st_en, m_alignment_change, m_oof, m_frame_recovered, cfg_ld, tx_bit, dchk, rac_d, lfall, tb_d;
  logic [4:0] esel;
  logic [2:0] fmt;
  logic [10:0] len;
  logic lclk, rx_frame_sync, tx_frame_sync, rx_serial_data, txd, treq, rd, rv, rsy, tsy, rac, tac, lof, rterm, tterm, sw, sc, adv, own, iv;
  logic [9:0] rpos, tpos;
  logic [6:0] rslot, tslot, sr, st;
  logic [1:0] icode;
  int err_count, n_checks, cyc, n_int [4], n_sc, n_so, n_adv, n_own, n_rise, nr, nt, a, b, c;
  tfsf_flywheel dut (.i_clock(clk), .i_rst(rst), .i_rx_line_clock(lclk), .i_tx_line_clock(lclk),
    .i_rx_frame_sync(rx_frame_sync), .i_tx_frame_sync(tx_frame_sync), .i_rx_out_of_frame_in(loss_of_frame), .i_rx_serial_data(rx_serial_data),
    .i_port_frame_format(fmt), .i_edge_sel(esel), .i_cfg_load(cfg_ld), .i_tx_bit(tx_bit),
    .i_oof_abort_enable(abt), .i_status_write_enable(st_en), .i_alignment_change_int_mask(m_alignment_change),
    .i_oof_int_mask(m_oof), .i_frame_recovered_int_mask(m_frame_recovered), .o_tx_serial_data(txd), .o_tx_bit_req(treq),
    .o_rx_data(rd), .o_rx_data_valid(rv), .o_rx_bit_pos(rpos), .o_tx_bit_pos(tpos), .o_rx_slot(rslot),
    .o_tx_slot(tslot), .o_rx_synced(rsy), .o_tx_synced(tsy), .o_rx_alignment_change(rac),
    .o_tx_alignment_change(tac), .o_loss_of_frame(lof), .o_rx_terminate(rterm), .o_tx_terminate(tterm),
    .o_status_write(sw), .o_status_code(sc), .o_desc_advance(adv), .o_owner_return(own),
    .o_int_valid(iv), .o_int_code(icode));
  tfsf_framer_model frm (.i_rst(rst), .i_len(len), .i_sync_en(sync_en), .i_nx64(nx64), .i_slip(slip),
    .i_launch_fall(lfall),
    .o_line_clock(lclk), .o_rx_frame_sync(rx_frame_sync), .o_tx_frame_sync(tx_frame_sync), .o_rx_serial_data(rx_serial_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_pos0(input bit tx);
    while (!(tx ? (treq && tpos == 10'h000) : (rv && rpos == 10'h000))) @(posedge clk);
  endtask
  // counts bit events from one position zero to the next
  task automatic measure(input bit tx, output int n, output logic [6:0] last);
    n = 0;
    wait_pos0(tx);
    do begin
      @(posedge clk);
      if (tx ? treq : rv) begin
        n++;
        if ((tx ? tpos : rpos) != 10'h000) last = tx ? tslot : rslot;
      end
    end while (!((tx ? treq : rv) && (tx ? tpos : rpos) == 10'h000));
  endtask
  task automatic restart(input logic [2:0] f, input logic [10:0] l);
    @(posedge clk);
    rst <= 1'b1;
    fmt <= f;
    len <= l;
    sync_en <= 1'b1;
    wait_cyc(4);
    rst <= 1'b0;
    do @(posedge clk); while (rsy !== 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    rac_d <= rac;
    tx_bit <= tpos[2];
    tb_d <= tx_bit;
    if (iv) n_int[icode]++;
    if (sw && sc === tfsf_pkg::STAT_ALIGNMENT_CHANGE) n_sc++;
    if (sw && sc === tfsf_pkg::STAT_OOF) n_so++;
    if (adv) n_adv++;
    if (own) n_own++;
    if (rac && !rac_d) n_rise++;
    if (dchk && rv) check(rd, rpos[1], "rx data");
    if (dchk && treq) check(txd, tb_d, "tx data");
    if (cyc == CEIL) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{tfsf_pkg::FMT_T1, 193, 23};
    rows[1] = '{tfsf_pkg::FMT_E1, 256, 31};
    rows[2] = '{tfsf_pkg::FMT_2E1, 512, 63};
    rows[3] = '{tfsf_pkg::FMT_4E1, 1024, 127};
    {rst, sync_en, nx64, slip, loss_of_frame, abt, st_en, m_alignment_change, m_oof, m_frame_recovered, cfg_ld, tx_bit, dchk} = 13'h1000;
    lfall = 1'b0;
    esel = tfsf_pkg::EDGE_RESET;
    fmt = tfsf_pkg::FMT_E1;
    len = 11'h100;
    wait_cyc(16);
    check({rsy, tsy, rac, tac, lof, iv, rv, treq}, 8'h00, "reset outputs");
    rst <= 1'b0;
    foreach (rows[i]) begin
      restart(rows[i].fmt, rows[i].len[10:0]);
      check(rac, 1'b1, "first sync flag");
      check(rpos, 10'h000, "aligned position");
      sync_en <= 1'b0;
      dchk <= 1'b1;
      fork
        measure(1'b0, nr, sr);
        measure(1'b1, nt, st);
      join
      dchk <= 1'b0;
      check(nr, rows[i].len, "rx frame");
      check(nt, rows[i].len, "tx frame");
      check(sr, rows[i].slot, "rx last slot");
      check(st, rows[i].slot, "tx last slot");
      wait_cyc(20);
      check(n_int[0], i + 1, "rx align int");
      check(n_int[1], i + 1, "tx align int");
      $display("test format %0d done", rows[i].fmt);
    end
    // unexpected sync from a slipped frame, interrupt masked
    restart(tfsf_pkg::FMT_E1, 11'h100);
    st_en <= 1'b1;
    wait_cyc(2200);
    m_alignment_change <= 1'b1;
    a = n_adv;
    b = n_int[0] + n_int[1];
    c = n_sc;
    slip <= ~slip;
    do @(posedge clk); while (rac !== 1'b1);
    wait_cyc(5);
    check(n_sc - c, 1, "align status");
    check(n_adv - a, 1, "align advance");
    check(rterm, 1'b1, "align terminate");
    check(tterm, 1'b1, "tx align terminate");
    wait_cyc(4500);
    check(n_int[0] + n_int[1] - b, 0, "masked align int");
    $display("test alignment change done");
    // out of frame with abort, then recovery
    m_alignment_change <= 1'b0;
    abt <= 1'b1;
    a = n_own;
    b = n_int[2];
    c = n_so;
    loss_of_frame <= 1'b1;
    do @(posedge clk); while (lof !== 1'b1);
    wait_cyc(3);
    check(rterm, 1'b1, "oof terminate");
    check(n_own - a, 1, "owner return");
    check(n_so - c, 1, "oof status");
    wait_cyc(1900);
    check(n_int[2] - b, 0, "oof int early");
    wait_cyc(2400);
    check(n_int[2] - b, 1, "oof int");
    b = n_int[3];
    loss_of_frame <= 1'b0;
    do @(posedge clk); while (lof !== 1'b0);
    check(rterm, 1'b0, "resume");
    wait_cyc(1900);
    check(n_int[3] - b, 0, "recovery int early");
    wait_cyc(2400);
    check(n_int[3] - b, 1, "recovery int");
    $display("test out of frame abort done");
    // out of frame without abort, both interrupts masked
    abt <= 1'b0;
    m_oof <= 1'b1;
    m_frame_recovered <= 1'b1;
    a = n_own;
    b = n_int[2] + n_int[3];
    loss_of_frame <= 1'b1;
    do @(posedge clk); while (lof !== 1'b1);
    wait_cyc(3);
    check(rterm, 1'b0, "no abort terminate");
    check(n_own - a, 0, "no abort owner");
    wait_cyc(4300);
    loss_of_frame <= 1'b0;
    wait_cyc(4400);
    check(n_int[2] + n_int[3] - b, 0, "masked oof ints");
    $display("test out of frame masked done");
    // nx64 of five slots, frame set only by syncs
    // all sampling on rising edges here, so the far end launches on falling ones
    nx64 <= 1'b1;
    cfg_ld <= 1'b1;
    slip <= 1'b0;
    lfall <= 1'b1;
    esel <= 5'h1f;
    b = n_rise;
    restart(tfsf_pkg::FMT_NX64, 11'h028);
    dchk <= 1'b1;
    fork
      measure(1'b0, nr, sr);
      measure(1'b1, nt, st);
    join
    dchk <= 1'b0;
    check({tpos, rpos}, 20'h00000, "nx64 bit zero aligned");
    check(nr, 40, "nx64 rx frame");
    check(nt, 40, "nx64 tx frame");
    check(n_rise - b, 0, "no nx64 align");
    $display("test nx64 done");
    give_verdict();
  end
endmodule

// [verification/tfsf_framer_model.sv]
// Purpose: far end framer driving line clock, frame syncs and rx data
// Assumes: syncs and data launched on the rising line clock edge, or the falling one with i_launch_fall
// Notes: toggling i_slip shortens one frame so the next sync lands unexpected
`timescale 1ns/10ps
module tfsf_framer_model (
  input wire logic i_rst,
  input wire logic [10:0] i_len,
  input wire logic i_sync_en,
  input wire logic i_nx64,
  input wire logic i_slip,
  input wire logic i_launch_fall,
  output logic o_line_clock,
  output logic o_rx_frame_sync,
  output logic o_tx_frame_sync,
  output logic o_rx_serial_data
);
  logic [10:0] cnt;
  logic slip_seen;
  logic lc;
  // launch on the edge opposite to the one the device samples on
  assign lc = o_line_clock ^ i_launch_fall;
  // phase offset keeps line edges away from the system clock edges
  initial begin
    o_line_clock = 1'b0;
    #237;
    forever #400 o_line_clock = ~o_line_clock;
  end
  always @(posedge lc or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 11'h000;
      slip_seen <= 1'b0;
    end else begin
      slip_seen <= i_slip;
      if (cnt + 11'h001 + {10'h000, i_slip ^ slip_seen} >= i_len) begin
        cnt <= 11'h000;
      end else begin
        cnt <= cnt + 11'h001 + {10'h000, i_slip ^ slip_seen};
      end
    end
  end
  // sync stands a whole line clock, once in every frame
  assign o_rx_frame_sync = i_sync_en && (cnt == 11'h000);
  assign o_tx_frame_sync = i_sync_en && (cnt == (i_nx64 ? i_len - 11'h004 : 11'h000));
  assign o_rx_serial_data = cnt[1];
endmodule

// [verilog/tfsf_flywheel.sv]
// Purpose: receive and transmit frame flywheels with alignment change and out-of-frame handling
// Assumes: line clocks far slower than i_clock; line clock, sync, out-of-frame and rx data pins pass two flip-flops
// Notes: descriptor writes leave as one-cycle pulses; message termination is held as a level
`timescale 1ns/10ps
// Operation
// - flywheel counts bit positions and wraps at the selected format's frame length
// - a sampled frame sync rise marks bit position zero
// - separate receive and transmit flywheels
// - once aligned, counting continues without further sync pulses
// - time slot index restarts each frame and follows the serviced slot
// - T1 wraps after 193 bits: framing bit plus 24 slots
// - E1 wraps after 256 bits, 32 slots
// - double E1 wraps after 512 bits, 64 slots
// - quad E1 wraps after 1024 bits, 128 slots
// - Nx64 frame length comes only from sync pulses
// - Nx64 transmit sync precedes bit zero by exactly 4 line clocks
// - sync and data sampling edges selectable separately per signal
// - unexpected sync or first sync while unaligned flags alignment change
// - alignment change flag lasts one frame and terminates active messages
// - receive termination writes status if enabled and advances descriptor in the same cycle
// - falling alignment change flag queues interrupt unless masked
// - sync rise during flag queues interrupt at once; no detection in Nx64
// - out-of-frame input sampled on every time slot bit
// - out-of-frame with abort terminates receive messages, else data keeps flowing
// - out-of-frame termination returns ownership and writes status if enabled
// - out-of-frame interrupt two frame sync events after assertion unless masked
// - recovery resumes at once; recovery interrupt two frame syncs later
// - after reset every signal uses the falling line clock edge
module tfsf_flywheel (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rx_line_clock,
  input wire logic i_tx_line_clock,
  input wire logic i_rx_frame_sync,
  input wire logic i_tx_frame_sync,
  input wire logic i_rx_out_of_frame_in,
  input wire logic i_rx_serial_data,
  input wire logic [2:0] i_port_frame_format,
  input wire logic [4:0] i_edge_sel,
  input wire logic i_cfg_load,
  input wire logic i_tx_bit,
  input wire logic i_oof_abort_enable,
  input wire logic i_status_write_enable,
  input wire logic i_alignment_change_int_mask,
  input wire logic i_oof_int_mask,
  input wire logic i_frame_recovered_int_mask,
  output logic o_tx_serial_data,
  output logic o_tx_bit_req,
  output logic o_rx_data,
  output logic o_rx_data_valid,
  output logic [9:0] o_rx_bit_pos,
  output logic [9:0] o_tx_bit_pos,
  output logic [6:0] o_rx_slot,
  output logic [6:0] o_tx_slot,
  output logic o_rx_synced,
  output logic o_tx_synced,
  output logic o_rx_alignment_change,
  output logic o_tx_alignment_change,
  output logic o_loss_of_frame,
  output logic o_rx_terminate,
  output logic o_tx_terminate,
  output logic o_status_write,
  output logic o_status_code,
  output logic o_desc_advance,
  output logic o_owner_return,
  output logic o_int_valid,
  output logic [1:0] o_int_code
);
  tfsf_pkg::tfsf_state_t st;
  tfsf_pkg::tfsf_state_t next_st;
  logic [10:0] len;
  logic nx;
  logic [5:0] rise;
  logic [5:0] fall;
  logic ev_rx_sync, ev_tx_sync, ev_rx_tick, ev_tx_tick, ev_oof;
  logic rx_eff, tx_eff, rx_alignment_change_set, tx_alignment_change_set, rx_drop, tx_drop;
  logic rx_early, tx_early, rx_fsync, tx_fsync, oof_eval;
  logic [3:0] int_set;
  logic [3:0] grant;

  // ---------------------------------------------------------------
  // one flywheel step, shared by both directions
  // ---------------------------------------------------------------
  function automatic tfsf_pkg::tfsf_dir_t step(
    input tfsf_pkg::tfsf_dir_t d,
    input logic sync_ev,
    input logic lvl,
    input logic tick,
    input logic [10:0] flen,
    input logic nx64,
    input logic is_tx,
    output logic eff,
    output logic alignment_change_set,
    output logic drop,
    output logic early,
    output logic fsync
  );
    tfsf_pkg::tfsf_dir_t n;
    logic [9:0] last;
    n = d;
    last = 10'(flen - 11'h001);
    alignment_change_set = 1'b0;
    drop = 1'b0;
    early = 1'b0;
    // a long sync pulse only counts once: the rise is what aligns
    if (sync_ev) begin
      n.samp = lvl;
      if (lvl && !d.samp) begin
        n.pend = 1'b1;
      end
    end
    eff = n.pend;
    if (tick) begin
      n.pend = 1'b0;
      if (eff && is_tx && nx64) begin
        n.lead = tfsf_pkg::TX_LEAD;
        n.pos = d.pos + 10'h001;
      end else if (eff) begin
        alignment_change_set = !nx64 && (!d.synced || d.pos != last);
        early = d.alignment_change && !nx64;
        n.synced = 1'b1;
        n.pos = 10'h000;
        n.lead = 3'h0;
      end else if (d.lead == 3'h1) begin
        n.lead = 3'h0;
        n.synced = 1'b1;
        n.pos = 10'h000;
      end else begin
        if (d.lead != 3'h0) begin
          n.lead = d.lead - 3'h1;
        end
        // Nx64 has no known length, so it only rolls at the counter's end
        n.pos = (!nx64 && d.pos == last) ? 10'h000 : d.pos + 10'h001;
      end
      if (alignment_change_set) begin
        n.alignment_change = 1'b1;
        n.cnt = 11'h000;
      end else if (d.alignment_change) begin
        if (d.cnt == flen - 11'h001) begin
          n.alignment_change = 1'b0;
          drop = !early;
        end else begin
          n.cnt = d.cnt + 11'h001;
        end
      end
    end
    fsync = tick && n.pos == 10'h000 && d.pos != 10'h000;
    return n;
  endfunction

  // ---------------------------------------------------------------
  // frame length from format
  // ---------------------------------------------------------------
  always_comb begin
    nx = 1'b0;
    unique case (i_port_frame_format)
      tfsf_pkg::FMT_T1: len = tfsf_pkg::LEN_T1;
      tfsf_pkg::FMT_E1: len = tfsf_pkg::LEN_E1;
      tfsf_pkg::FMT_2E1: len = tfsf_pkg::LEN_2E1;
      tfsf_pkg::FMT_4E1: len = tfsf_pkg::LEN_4E1;
      default: begin
        len = tfsf_pkg::LEN_4E1;
        nx = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // edge detection on the synchronised line clocks
  // ---------------------------------------------------------------
  always_comb begin
    rise = {6{1'b0}};
    fall = {6{1'b0}};
    rise[1:0] = st.meta2[1:0] & ~st.clk_d;
    fall[1:0] = ~st.meta2[1:0] & st.clk_d;
    ev_rx_sync = st.cfg[tfsf_pkg::EDGE_RX_SYNC] ? rise[0] : fall[0];
    ev_tx_sync = st.cfg[tfsf_pkg::EDGE_TX_SYNC] ? rise[1] : fall[1];
    ev_rx_tick = st.cfg[tfsf_pkg::EDGE_RX_DATA] ? rise[0] : fall[0];
    ev_tx_tick = st.cfg[tfsf_pkg::EDGE_TX_DATA] ? rise[1] : fall[1];
    ev_oof = st.cfg[tfsf_pkg::EDGE_OOF] ? rise[0] : fall[0];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    int_set = 4'h0;
    grant = 4'h0;
    next_st.meta1 = {i_rx_serial_data, i_rx_out_of_frame_in, i_tx_frame_sync, i_rx_frame_sync,
                     i_tx_line_clock, i_rx_line_clock};
    next_st.meta2 = st.meta1;
    next_st.clk_d = st.meta2[1:0];
    if (i_cfg_load) begin
      next_st.cfg = i_edge_sel;
    end
    next_st.rx = step(st.rx, ev_rx_sync, st.meta2[tfsf_pkg::IN_RX_SYNC], ev_rx_tick, len, nx, 1'b0,
                      rx_eff, rx_alignment_change_set, rx_drop, rx_early, rx_fsync);
    next_st.tx = step(st.tx, ev_tx_sync, st.meta2[tfsf_pkg::IN_TX_SYNC], ev_tx_tick, len, nx, 1'b1,
                      tx_eff, tx_alignment_change_set, tx_drop, tx_early, tx_fsync);
    next_st.rx_valid = ev_rx_tick;
    next_st.tx_req = ev_tx_tick;
    if (ev_rx_tick) begin
      next_st.rx_bit = st.meta2[tfsf_pkg::IN_RX_DATA];
    end
    if (ev_tx_tick) begin
      next_st.tx_bit = i_tx_bit;
    end
    if (ev_oof) begin
      next_st.oof_samp = st.meta2[tfsf_pkg::IN_OOF];
    end
    // the T1 framing bit belongs to no slot, so out-of-frame is not looked at there
    oof_eval = ev_rx_tick && !(i_port_frame_format == tfsf_pkg::FMT_T1 && next_st.rx.pos == 10'h000);
    next_st.st_wr = 1'b0;
    next_st.advance = 1'b0;
    next_st.owner = 1'b0;
    if (rx_alignment_change_set) begin
      next_st.st_wr = i_status_write_enable;
      next_st.st_code = tfsf_pkg::STAT_ALIGNMENT_CHANGE;
      next_st.advance = 1'b1;
    end
    if (oof_eval && st.oof_samp != st.loss_of_frame) begin
      next_st.loss_of_frame = st.oof_samp;
      next_st.oof_ph = st.oof_samp ? tfsf_pkg::OOF_LOST : tfsf_pkg::OOF_RECOV;
      next_st.oof_evt = 2'h0;
      if (st.oof_samp && i_oof_abort_enable) begin
        next_st.st_wr = i_status_write_enable;
        next_st.st_code = tfsf_pkg::STAT_OOF;
        next_st.advance = 1'b1;
        next_st.owner = 1'b1;
      end
    end else if (rx_fsync && st.oof_ph != tfsf_pkg::OOF_IDLE) begin
      next_st.oof_evt = st.oof_evt + 2'h1;
      if (st.oof_evt + 2'h1 == tfsf_pkg::OOF_EVENTS) begin
        next_st.oof_ph = tfsf_pkg::OOF_IDLE;
        int_set[tfsf_pkg::INT_OOF] = st.oof_ph == tfsf_pkg::OOF_LOST && !i_oof_int_mask;
        int_set[tfsf_pkg::INT_FRAME_RECOVERED] = st.oof_ph == tfsf_pkg::OOF_RECOV && !i_frame_recovered_int_mask;
      end
    end
    int_set[tfsf_pkg::INT_RX_ALIGNMENT_CHANGE] = (rx_drop || rx_early) && !i_alignment_change_int_mask;
    int_set[tfsf_pkg::INT_TX_ALIGNMENT_CHANGE] = (tx_drop || tx_early) && !i_alignment_change_int_mask;
    // one descriptor per cycle, lowest code first; a new event beats the grant
    for (int i = 3; i >= 0; i--) begin
      if (st.pend_int[i]) begin
        grant = 4'h0;
        grant[i] = 1'b1;
      end
    end
    next_st.int_v = |grant;
    next_st.int_code = grant[3] ? 2'h3 : grant[2] ? 2'h2 : grant[1] ? 2'h1 : 2'h0;
    next_st.pend_int = (st.pend_int & ~grant) | int_set;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [9:0] rx_off;
  logic [9:0] tx_off;
  always_comb begin
    rx_off = st.rx.pos;
    tx_off = st.tx.pos;
    if (i_port_frame_format == tfsf_pkg::FMT_T1) begin
      rx_off = (st.rx.pos == 10'h000) ? 10'h000 : st.rx.pos - 10'h001;
      tx_off = (st.tx.pos == 10'h000) ? 10'h000 : st.tx.pos - 10'h001;
    end
  end
  assign o_rx_slot = rx_off[9:3];
  assign o_tx_slot = tx_off[9:3];
  assign o_rx_bit_pos = st.rx.pos;
  assign o_tx_bit_pos = st.tx.pos;
  assign o_rx_synced = st.rx.synced;
  assign o_tx_synced = st.tx.synced;
  assign o_rx_alignment_change = st.rx.alignment_change;
  assign o_tx_alignment_change = st.tx.alignment_change;
  assign o_loss_of_frame = st.loss_of_frame;
  assign o_rx_terminate = st.rx.alignment_change || (st.loss_of_frame && i_oof_abort_enable);
  assign o_tx_terminate = st.tx.alignment_change;
  assign o_tx_serial_data = st.tx_bit;
  assign o_tx_bit_req = st.tx_req;
  assign o_rx_data = st.rx_bit;
  assign o_rx_data_valid = st.rx_valid;
  assign o_status_write = st.st_wr;
  assign o_status_code = st.st_code;
  assign o_desc_advance = st.advance;
  assign o_owner_return = st.owner;
  assign o_int_valid = st.int_v;
  assign o_int_code = st.int_code;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_SYNC_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_rx_tick && rx_eff) |=> (st.rx.pos == 10'h000 && st.rx.synced))
    else $error("rx sync did not set position zero");
  AST_T1_WRAP: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_rx_tick && !rx_eff && i_port_frame_format == tfsf_pkg::FMT_T1 && st.rx.pos == 10'd192)
    |=> st.rx.pos == 10'h000)
    else $error("T1 frame did not wrap at 193");
  AST_E1_WRAP: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_rx_tick && !rx_eff && i_port_frame_format == tfsf_pkg::FMT_E1 && st.rx.pos == 10'd255)
    |=> st.rx.pos == 10'h000)
    else $error("E1 frame did not wrap at 256");
  AST_2E1_WRAP: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_tx_tick && !tx_eff && i_port_frame_format == tfsf_pkg::FMT_2E1 && st.tx.pos == 10'd511)
    |=> st.tx.pos == 10'h000)
    else $error("double E1 frame did not wrap at 512");
  AST_FREE_RUN: assert property (@(posedge i_clock) disable iff (i_rst)
    (st.rx.synced && ev_rx_tick && !rx_eff && st.rx.pos == 10'd9) |=> st.rx.pos == 10'd10)
    else $error("flywheel failed to advance");
  AST_NX_LEAD: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_tx_tick && tx_eff && nx) |=> st.tx.lead == tfsf_pkg::TX_LEAD)
    else $error("Nx64 transmit lead not loaded");
  AST_NX_BIT0: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_tx_tick && !tx_eff && st.tx.lead == 3'h1) |=> (st.tx.pos == 10'h000 && st.tx.synced))
    else $error("Nx64 transmit bit zero not at end of lead");
  AST_FIRST_ALIGNMENT_CHANGE: assert property (@(posedge i_clock) disable iff (i_rst)
    (ev_rx_tick && rx_eff && !st.rx.synced && !nx) |=> st.rx.alignment_change)
    else $error("first sync did not flag alignment change");
  AST_NX_NO_ALIGNMENT_CHANGE: assert property (@(posedge i_clock) disable iff (i_rst)
    nx |-> !rx_alignment_change_set && !tx_alignment_change_set)
    else $error("alignment change flagged in Nx64");
  AST_ALIGNMENT_CHANGE_INT: assert property (@(posedge i_clock) disable iff (i_rst)
    (rx_drop && !i_alignment_change_int_mask) |=> ##[0:4] (o_int_valid && o_int_code == tfsf_pkg::INT_RX_ALIGNMENT_CHANGE))
    else $error("alignment change interrupt missing");
  AST_OOF_ABORT: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_loss_of_frame) |-> (o_owner_return == $past(i_oof_abort_enable)))
    else $error("out-of-frame abort did not terminate");
  AST_OOF_STATUS: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_owner_return) |-> (o_desc_advance && o_status_code == tfsf_pkg::STAT_OOF
    && o_status_write == $past(i_status_write_enable)))
    else $error("out-of-frame termination incomplete");
  COV_E1_WRAP: cover property (@(posedge i_clock) disable iff (i_rst)
    st.rx.synced && i_port_frame_format == tfsf_pkg::FMT_E1 && $fell(st.rx.pos[9]) == 1'b0
    && st.rx.pos == 10'h000 && $past(st.rx.pos) == 10'd255);
  COV_ALIGNMENT_CHANGE: cover property (@(posedge i_clock) disable iff (i_rst) rx_drop);
  COV_OOF_INT: cover property (@(posedge i_clock) disable iff (i_rst)
    o_int_valid && o_int_code == tfsf_pkg::INT_OOF);
  COV_FRAME_RECOVERED_INT: cover property (@(posedge i_clock) disable iff (i_rst)
    o_int_valid && o_int_code == tfsf_pkg::INT_FRAME_RECOVERED);
endmodule

// [verilog/tfsf_pkg.sv]
// Purpose: constants and state types of the tdm frame sync flywheel
// Assumes: one 10 MHz system clock samples the slow line clocks
// Notes: edge select bits read 1 for rising, 0 for falling
package tfsf_pkg;
  // ---------------------------------------------------------------
  // frame formats and frame lengths
  // ---------------------------------------------------------------
  localparam logic [2:0] FMT_T1 = 3'h0;
  localparam logic [2:0] FMT_E1 = 3'h1;
  localparam logic [2:0] FMT_2E1 = 3'h2;
  localparam logic [2:0] FMT_4E1 = 3'h3;
  localparam logic [2:0] FMT_NX64 = 3'h4;
  localparam logic [10:0] LEN_T1 = 11'h0c1;
  localparam logic [10:0] LEN_E1 = 11'h100;
  localparam logic [10:0] LEN_2E1 = 11'h200;
  localparam logic [10:0] LEN_4E1 = 11'h400;
  localparam logic [2:0] TX_LEAD = 3'h4;
  localparam logic [1:0] OOF_EVENTS = 2'h2;
  // ---------------------------------------------------------------
  // edge select positions, synchroniser positions, codes
  // ---------------------------------------------------------------
  localparam int EDGE_RX_SYNC = 0;
  localparam int EDGE_TX_SYNC = 1;
  localparam int EDGE_RX_DATA = 2;
  localparam int EDGE_TX_DATA = 3;
  localparam int EDGE_OOF = 4;
  localparam logic [4:0] EDGE_RESET = 5'h00;
  localparam int IN_RX_CLK = 0;
  localparam int IN_TX_CLK = 1;
  localparam int IN_RX_SYNC = 2;
  localparam int IN_TX_SYNC = 3;
  localparam int IN_OOF = 4;
  localparam int IN_RX_DATA = 5;
  localparam logic [1:0] INT_RX_ALIGNMENT_CHANGE = 2'h0;
  localparam logic [1:0] INT_TX_ALIGNMENT_CHANGE = 2'h1;
  localparam logic [1:0] INT_OOF = 2'h2;
  localparam logic [1:0] INT_FRAME_RECOVERED = 2'h3;
  localparam logic STAT_ALIGNMENT_CHANGE = 1'h0;
  localparam logic STAT_OOF = 1'h1;

  typedef enum logic [1:0] {OOF_IDLE, OOF_LOST, OOF_RECOV} tfsf_oof_t;

  typedef struct packed {
    logic [9:0] pos;
    logic synced;
    logic samp;
    logic pend;
    logic [2:0] lead;
    logic alignment_change;
    logic [10:0] cnt;
  } tfsf_dir_t;

  typedef struct packed {
    logic [5:0] meta1;
    logic [5:0] meta2;
    logic [1:0] clk_d;
    logic [4:0] cfg;
    tfsf_dir_t rx;
    tfsf_dir_t tx;
    logic oof_samp;
    logic loss_of_frame;
    tfsf_oof_t oof_ph;
    logic [1:0] oof_evt;
    logic [3:0] pend_int;
    logic int_v;
    logic [1:0] int_code;
    logic tx_bit;
    logic tx_req;
    logic rx_bit;
    logic rx_valid;
    logic st_wr;
    logic st_code;
    logic advance;
    logic owner;
  } tfsf_state_t;
endpackage
